// ### logic/status_user_buffer.sv
// Purpose: capture, host and transmit buffers for channel status and user data
// Assumes: frame strobes come from logic on ref_clk, frames >= 64 clocks apart
// Notes: host reaches the middle buffer through a byte-wide data port
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
module status_user_buffer (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [status_buf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_frame_stb,
  input wire logic rx_block_start,
  input wire logic rx_c_a,
  input wire logic rx_c_b,
  input wire logic rx_u_a,
  input wire logic rx_u_b,
  input wire logic tx_frame_stb,
  output logic tx_c_a,
  output logic tx_c_b,
  output logic tx_u_a,
  output logic tx_u_b,
  output logic tx_block_first,
  output logic cap_xfer_irq,
  output logic tx_xfer_irq
);
  import status_buf_pkg::*;

  logic [CTRL_W-1:0] ctrl;
  logic [PTR_W-1:0] ptr;
  logic phase;
  logic [7:0] hold;
  logic h_wait;
  logic h_wr;
  mover_e mstate;
  mover_e next_mstate;
  logic [ROW_W-1:0] mcnt;
  logic cap_pend;
  logic tx_pend;
  logic [7:0] cap_cnt;
  logic [7:0] tx_cnt;
  logic [7:0] rx_idx;
  logic [7:0] rx_a_sh;
  logic [7:0] rx_b_sh;
  logic [15:0] rx_u_sh;
  logic [7:0] tx_idx;
  logic [15:0] cs_sh;
  logic [15:0] u_sh;
  logic fetch_pend;
  logic fetch_ld;
  logic [ROW_W-1:0] fetch_row;
  logic pro_a;
  logic pro_b;
  logic [7:0] crc_a;
  logic [7:0] crc_b;
  logic [31:0] d_rdata;
  logic [31:0] e_rdata;
  logic [31:0] f_rdata;

  // receive side: assemble bytes msb-first, one row every eight frames
  wire [7:0] rx_f = rx_block_start ? 8'h00 : rx_idx;
  wire [7:0] next_rx_a = {rx_a_sh[6:0], rx_c_a};
  wire [7:0] next_rx_b = {rx_b_sh[6:0], rx_c_b};
  wire [15:0] next_rx_u = {rx_u_sh[13:0], rx_u_a, rx_u_b};
  wire rx_word_end = rx_frame_stb & (rx_f[2:0] == GROUP_LAST);
  wire rx_block_end = rx_frame_stb & (rx_f == FRAME_LAST);
  wire cap_set = rx_block_end & ~ctrl[CB_INH_CAP];
  wire tx_block_end = tx_frame_stb & (tx_idx == FRAME_LAST);
  wire tx_set = tx_block_end & ~ctrl[CB_INH_TX];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_idx <= 8'h00;
      rx_a_sh <= 8'h00;
      rx_b_sh <= 8'h00;
      rx_u_sh <= 16'h0000;
    end else if (rx_frame_stb) begin
      rx_idx <= (rx_f == FRAME_LAST) ? 8'h00 : rx_f + 8'h01;
      rx_a_sh <= next_rx_a;
      rx_b_sh <= next_rx_b;
      rx_u_sh <= next_rx_u;
    end
  end

  // host register and data port decode
  wire acc = psel & penable & ~pready & ~h_wait;
  wire sel_ctrl = (paddr == OFF_CTRL);
  wire sel_status = (paddr == OFF_STATUS);
  wire sel_ptr = (paddr == OFF_PTR);
  wire sel_data = (paddr == OFF_DATA);
  wire mapped = sel_ctrl | sel_status | sel_ptr | sel_data;
  wire acc_reg = acc & ~sel_data;
  wire host_go = acc & sel_data & (mstate == M_IDLE);
  wire is_u = (ptr >= PTR_U_BASE);
  wire [PTR_W-1:0] u_off = ptr - PTR_U_BASE;
  wire [ROW_W-1:0] row = is_u ? u_off[ROW_W-1:0] : ptr[ROW_W-1:0];
  wire two_b = is_u | ctrl[CB_TWO_BYTE];
  wire hi = two_b ? ~phase : ~ctrl[CB_SEL_B];
  wire [7:0] rd_byte = is_u ? (hi ? e_rdata[15:8] : e_rdata[7:0])
                            : (hi ? e_rdata[31:24] : e_rdata[23:16]);
  wire [7:0] wbyte = pwdata[7:0];
  wire last_byte = ~two_b | phase;
  wire [PTR_W-1:0] next_ptr = (ptr == PTR_LAST) ? '0 : ptr + 6'h01;
  wire host_we = host_go & pwrite & last_byte;
  // first byte of a pair is held until the second arrives
  wire [31:0] host_wdata = is_u ? {16'h0000, hold, wbyte}
                         : two_b ? {hold, wbyte, 16'h0000}
                         : {wbyte, wbyte, 16'h0000};
  wire [31:0] host_mask = is_u ? MASK_U : MASK_CS;
  wire [31:0] status_word = (32'(mstate != M_IDLE) << SB_BUSY)
                          | (32'(pro_a) << SB_PRO_A)
                          | (32'(pro_b) << SB_PRO_B)
                          | (32'(cap_cnt) << SB_CAP_CNT)
                          | (32'(tx_cnt) << SB_TX_CNT);
  wire [31:0] reg_rd = sel_ctrl ? 32'(ctrl)
                     : sel_status ? status_word
                     : sel_ptr ? (32'(ptr) | (32'(phase) << PB_PHASE))
                     : 32'h00000000;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl <= CTRL_RESET;
      ptr <= '0;
      phase <= 1'b0;
      hold <= 8'h00;
      h_wait <= 1'b0;
      h_wr <= 1'b0;
    end else begin
      h_wait <= host_go;
      if (host_go) begin
        h_wr <= pwrite;
      end
      if (host_go && pwrite && !last_byte) begin
        hold <= wbyte;
      end
      if (pready) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end else if (acc_reg) begin
        pready <= 1'b1;
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h00000000 : reg_rd;
        if (pwrite && sel_ctrl) begin
          ctrl <= pwdata[CTRL_W-1:0];
        end
        if (pwrite && sel_ptr) begin
          ptr <= pwdata[PTR_W-1:0];
          phase <= 1'b0;
        end
      end else if (h_wait) begin
        pready <= 1'b1;
        prdata <= h_wr ? 32'h00000000 : 32'(rd_byte);
        phase <= ~last_byte;
        if (last_byte) begin
          ptr <= next_ptr;
        end
      end
    end
  end

  // block mover: one whole-block copy at a time, host data port waits meanwhile
  wire free = (mstate == M_IDLE) & ~host_go & ~h_wait;
  wire cap_go = free & cap_pend;
  wire tx_go = free & tx_pend & ~cap_pend;
  wire m_last = (mstate != M_IDLE) & (mcnt == ROW_END);
  wire [ROW_W-1:0] mrow = mcnt - 5'h01;
  wire m_we = (mstate != M_IDLE) & (mcnt != 5'h00);
  wire [31:0] cap_mask = (ctrl[CB_RESERVE] && mrow < RES_ROWS)
                       ? MASK_U : MASK_ALL;
  wire e_we = (m_we & (mstate == M_CAP)) | host_we;
  wire [ROW_W-1:0] e_waddr = (mstate == M_CAP) ? mrow : row;
  wire [31:0] e_wdata = (mstate == M_CAP) ? d_rdata : host_wdata;
  wire [31:0] e_mask = (mstate == M_CAP) ? cap_mask : host_mask;
  wire [ROW_W-1:0] e_raddr = (mstate == M_TX) ? mcnt : row;
  wire f_we = m_we & (mstate == M_TX);

  always_comb begin
    case (mstate)
      M_IDLE: next_mstate = cap_go ? M_CAP : (tx_go ? M_TX : M_IDLE);
      M_CAP, M_TX: next_mstate = m_last ? M_IDLE : mstate;
      default: next_mstate = M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mstate <= M_IDLE;
      mcnt <= '0;
      cap_pend <= 1'b0;
      tx_pend <= 1'b0;
      cap_cnt <= 8'h00;
      tx_cnt <= 8'h00;
      cap_xfer_irq <= 1'b0;
      tx_xfer_irq <= 1'b0;
    end else begin
      mstate <= next_mstate;
      mcnt <= (mstate == M_IDLE) ? 5'h00 : mcnt + 5'h01;
      // inhibited boundaries are dropped; a new boundary wins over start
      cap_pend <= cap_set | (cap_pend & ~cap_go);
      tx_pend <= tx_set | (tx_pend & ~tx_go);
      if (m_last && mstate == M_CAP) begin
        cap_cnt <= cap_cnt + 8'h01;
      end
      if (m_last && mstate == M_TX) begin
        tx_cnt <= tx_cnt + 8'h01;
      end
      cap_xfer_irq <= m_last & (mstate == M_CAP) & ctrl[CB_IE_CAP];
      tx_xfer_irq <= m_last & (mstate == M_TX) & ctrl[CB_IE_TX];
    end
  end

  // three cascaded block buffers
  block_ram #(.WIDTH(32), .DEPTH(ROWS), .AW(ROW_W)) u_capture_buf (
    .clk(ref_clk),
    .rstn(rstn),
    .we(rx_word_end),
    .waddr(rx_f[7:3]),
    .wdata({next_rx_a, next_rx_b, next_rx_u}),
    .wmask(MASK_ALL),
    .raddr(mcnt),
    .rdata(d_rdata)
  );

  block_ram #(.WIDTH(32), .DEPTH(ROWS), .AW(ROW_W)) u_host_buf (
    .clk(ref_clk),
    .rstn(rstn),
    .we(e_we),
    .waddr(e_waddr),
    .wdata(e_wdata),
    .wmask(e_mask),
    .raddr(e_raddr),
    .rdata(e_rdata)
  );

  block_ram #(.WIDTH(32), .DEPTH(ROWS), .AW(ROW_W)) u_transmit_buf (
    .clk(ref_clk),
    .rstn(rstn),
    .we(f_we),
    .waddr(mrow),
    .wdata(e_rdata),
    .wmask(MASK_ALL),
    .raddr(fetch_row),
    .rdata(f_rdata)
  );

  // transmit side: replays the transmit buffer until a new block lands,
  // so a slow input repeats blocks and a fast one loses whole blocks
  wire tx_word_end = tx_frame_stb & (tx_idx[2:0] == GROUP_LAST);
  wire [7:0] next_tx_idx = (tx_idx == FRAME_LAST) ? 8'h00 : tx_idx + 8'h01;
  wire fetch_go = fetch_pend & ~tx_pend & (mstate != M_TX);
  wire crc_zone = (tx_idx >= CRC_FIRST);
  wire first = (tx_idx == 8'h00);
  wire bit_a = cs_sh[15];
  wire bit_b = cs_sh[7];
  wire [7:0] crc_a_base = first ? CRC_INIT : crc_a;
  wire [7:0] crc_b_base = first ? CRC_INIT : crc_b;
  wire u_block = (ctrl[CB_UMODE +: 2] == UMODE_BLOCK);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_idx <= 8'h00;
      cs_sh <= 16'h0000;
      u_sh <= 16'h0000;
      fetch_pend <= 1'b1;
      fetch_ld <= 1'b0;
      fetch_row <= '0;
      pro_a <= 1'b0;
      pro_b <= 1'b0;
      crc_a <= CRC_INIT;
      crc_b <= CRC_INIT;
      tx_c_a <= 1'b0;
      tx_c_b <= 1'b0;
      tx_u_a <= 1'b0;
      tx_u_b <= 1'b0;
      tx_block_first <= 1'b0;
    end else begin
      fetch_pend <= tx_word_end | (fetch_pend & ~fetch_go);
      fetch_ld <= fetch_go;
      if (tx_word_end) begin
        fetch_row <= next_tx_idx[7:3];
      end
      if (fetch_ld) begin
        cs_sh <= f_rdata[31:16];
        u_sh <= f_rdata[15:0];
      end else if (tx_frame_stb) begin
        cs_sh <= {cs_sh[14:8], 1'b0, cs_sh[6:0], 1'b0};
        u_sh <= {u_sh[13:0], 2'b00};
      end
      if (tx_frame_stb) begin
        tx_idx <= next_tx_idx;
        tx_block_first <= first;
        if (first) begin
          pro_a <= bit_a;
          pro_b <= bit_b;
        end
        // check byte replaces the final status byte of a channel whose pro_a or pro_b bit is set
        tx_c_a <= (crc_zone && pro_a) ? crc_a[7] : bit_a;
        tx_c_b <= (crc_zone && pro_b) ? crc_b[7] : bit_b;
        crc_a <= crc_zone ? {crc_a[6:0], 1'b0} : crc_step(crc_a_base, bit_a);
        crc_b <= crc_zone ? {crc_b[6:0], 1'b0} : crc_step(crc_b_base, bit_b);
        // reserved and consumer codes fall back to zeros
        tx_u_a <= u_block & u_sh[15];
        tx_u_b <= u_block & u_sh[14];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_cap_start;
    mstate == M_IDLE ##1 mstate == M_CAP && mcnt == 5'h00;
  endsequence

  sequence s_cap_run;
    ##24 (mstate == M_CAP && mcnt == ROW_END) ##1 mstate != M_CAP;
  endsequence

  a_copy_whole: assert property (s_cap_start |-> s_cap_run)
    else $error("capture copy did not run exactly one block");
  a_cap_irq_fire: assert property (
    (mstate == M_CAP && m_last && ctrl[CB_IE_CAP]) |=> cap_xfer_irq)
    else $error("capture transfer gave no interrupt");
  a_irq_masked: assert property (
    !ctrl[CB_IE_TX] |=> !tx_xfer_irq)
    else $error("transmit interrupt while disabled");
  a_cap_inhibit: assert property (
    (rx_block_end && ctrl[CB_INH_CAP] && !cap_pend) |=> !cap_pend)
    else $error("inhibited capture transfer was queued");
  a_tx_bound: assert property (tx_pend |-> ##[0:120] mstate == M_TX)
    else $error("transmit transfer not started in time");
  a_reserve_keep: assert property (
    (e_we && mstate == M_CAP && ctrl[CB_RESERVE] && mrow < RES_ROWS)
    |-> e_mask[31:16] == 16'h0000)
    else $error("reserved bytes overwritten by capture");
  a_one_byte_dup: assert property (
    (host_we && !two_b) |-> e_wdata[31:24] == e_wdata[23:16])
    else $error("one-byte write not duplicated");
  a_two_byte_a: assert property (
    (h_wait && !h_wr && !is_u && two_b && !phase)
    |=> prdata[7:0] == $past(e_rdata[31:24]))
    else $error("two-byte read did not start with channel A");
  a_crc_out: assert property (
    (tx_frame_stb && crc_zone && pro_a) |=> tx_c_a == $past(crc_a[7]))
    else $error("check byte bit not transmitted");
  a_user_zero: assert property (
    (tx_frame_stb && ctrl[CB_UMODE +: 2] == UMODE_ZEROS)
    |=> !tx_u_a && !tx_u_b)
    else $error("user bit not zero in zeros mode");
endmodule : status_user_buffer

// ### logic/status_buf_pkg.sv
// Purpose: shared constants for the channel status / user data buffer block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: block rows hold {cs_a, cs_b, user_hi, user_lo}
package status_buf_pkg;
  // register offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PTR = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;
  // control register fields
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam int CB_INH_CAP = 0;
  localparam int CB_INH_TX = 1;
  localparam int CB_RESERVE = 2;
  localparam int CB_TWO_BYTE = 3;
  localparam int CB_SEL_B = 4;
  localparam int CB_UMODE = 5;
  localparam int CB_IE_CAP = 7;
  localparam int CB_IE_TX = 8;
  // status register fields
  localparam int SB_BUSY = 0;
  localparam int SB_PRO_A = 1;
  localparam int SB_PRO_B = 2;
  localparam int SB_CAP_CNT = 8;
  localparam int SB_TX_CNT = 16;
  // pointer register fields
  localparam int PB_PHASE = 6;
  // user bit modes
  localparam logic [1:0] UMODE_ZEROS = 2'h0;
  localparam logic [1:0] UMODE_BLOCK = 2'h1;
  localparam logic [1:0] UMODE_RSVD = 2'h2;
  localparam logic [1:0] UMODE_CONSUMER = 2'h3;
  // block geometry
  localparam int ROWS = 24;
  localparam int ROW_W = 5;
  localparam int PTR_W = 6;
  localparam logic [4:0] ROW_LAST = 5'h17;
  localparam logic [4:0] ROW_END = 5'h18;
  localparam logic [4:0] RES_ROWS = 5'h05;
  localparam logic [5:0] PTR_U_BASE = 6'h18;
  localparam logic [5:0] PTR_LAST = 6'h2f;
  localparam logic [7:0] FRAME_LAST = 8'hbf;
  localparam logic [7:0] CRC_FIRST = 8'hb8;
  localparam logic [2:0] GROUP_LAST = 3'h7;
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [31:0] MASK_CS = 32'hffff0000;
  localparam logic [31:0] MASK_U = 32'h0000ffff;
  localparam logic [31:0] MASK_ALL = 32'hffffffff;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_CAP = 2'h1,
    M_TX = 2'h3
  } mover_e;

  // one serial step of the status block check byte, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] crc,
                                          input logic din);
    logic fb;
    fb = crc[7] ^ din;
    crc_step = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction : crc_step
endpackage : status_buf_pkg

// ### logic/block_ram.sv
// Purpose: one block buffer, bit-masked write port, registered read port
// Assumes: single clock, out-of-range addresses are ignored
// Notes: no reset on the array; contents are undefined until written
module block_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 24,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH-1:0] wmask,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (int'(raddr) < DEPTH) begin
      rdata <= mem[raddr];
    end
  end
endmodule : block_ram

// ### verif/frame_partner.sv
// Purpose: audio-side partner, receive frame source and transmit frame sink
// Assumes: frames are 64 clocks apart, both streams on ref_clk
// Notes: status bytes are 8'h40+row (A) and 8'h90+row (B), msb sent first
module frame_partner (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic run_rx,
  input wire logic run_tx,
  output logic rx_frame_stb,
  output logic rx_block_start,
  output logic rx_c_a,
  output logic rx_c_b,
  output logic rx_u_a,
  output logic rx_u_b,
  output logic tx_frame_stb,
  input wire logic tx_c_a,
  input wire logic tx_c_b,
  input wire logic tx_u_a,
  input wire logic tx_u_b,
  input wire logic tx_block_first,
  output int rx_frames,
  output int tx_frames,
  output logic [15:0] u_seq,
  output logic [7:0] ca_seq,
  output logic [7:0] cb_seq,
  output logic [7:0] bf_seq,
  output logic u_any
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt;
  logic tx_live;

  function automatic logic pat(input int f, input logic [7:0] base);
    logic [7:0] b;
    b = base + 8'((f % 192) / 8);
    return b[7 - (f % 8)];
  endfunction : pat

  // data lines toggle between strobes so no stale bit can pass as valid
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {cnt, rx_frame_stb, rx_block_start, tx_frame_stb, tx_live} <= '0;
      {rx_c_a, rx_c_b, rx_u_a, rx_u_b, u_any} <= '0;
      {u_seq, ca_seq, cb_seq, bf_seq} <= '0;
      rx_frames <= 0;
      tx_frames <= 0;
    end else begin
      cnt <= cnt + 6'h1;
      rx_frame_stb <= run_rx && cnt == 6'h00;
      tx_frame_stb <= run_tx && cnt == 6'h00;
      if (run_rx && cnt == 6'h00) begin
        rx_block_start <= (rx_frames % 192) == 0;
        rx_c_a <= pat(rx_frames, 8'h40);
        rx_c_b <= pat(rx_frames, 8'h90);
        rx_u_a <= pat(rx_frames, 8'h21);
        rx_u_b <= pat(rx_frames, 8'h07);
        rx_frames <= rx_frames + 1;
      end else begin
        {rx_c_a, rx_c_b} <= ~{rx_c_a, rx_c_b};
        {rx_u_a, rx_u_b, rx_block_start} <= ~{rx_u_a, rx_u_b, rx_block_start};
      end
      if (run_tx && cnt == 6'h00) begin
        tx_frames <= tx_frames + 1;
        tx_live <= 1'b1;
      end else if (tx_live && cnt == 6'h20) begin
        tx_live <= 1'b0;
        u_seq <= {u_seq[13:0], tx_u_a, tx_u_b};
        ca_seq <= {ca_seq[6:0], tx_c_a};
        cb_seq <= {cb_seq[6:0], tx_c_b};
        bf_seq <= {bf_seq[6:0], tx_block_first};
        u_any <= u_any | tx_u_a | tx_u_b;
      end
    end
  end
endmodule : frame_partner

// ### verif/tb_status_user_buffer.sv
// Purpose: self-checking bench for the status and user buffer block
// Assumes: apb master tasks, partner streams frames on request
// Notes: capture and transmit phases run one after the other
module tb_status_user_buffer;
  import status_buf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] IE = (32'h1 << CB_IE_CAP) | (32'h1 << CB_IE_TX);
  localparam logic [31:0] TWO = 32'h1 << CB_TWO_BYTE;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_frame_stb, rx_block_start, rx_c_a, rx_c_b, rx_u_a, rx_u_b;
  logic tx_frame_stb, tx_c_a, tx_c_b, tx_u_a, tx_u_b, tx_block_first;
  logic cap_xfer_irq, tx_xfer_irq, run_rx, run_tx, u_any;
  logic [15:0] u_seq;
  logic [7:0] ca_seq, cb_seq, bf_seq;
  int rx_frames, tx_frames, n_fail, comparisons, cycles, n_cap, n_tx;

  status_user_buffer status_user_buffer_inst (.ref_clk(ref_clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_frame_stb(rx_frame_stb),
    .rx_block_start(rx_block_start), .rx_c_a(rx_c_a), .rx_c_b(rx_c_b),
    .rx_u_a(rx_u_a), .rx_u_b(rx_u_b), .tx_frame_stb(tx_frame_stb),
    .tx_c_a(tx_c_a), .tx_c_b(tx_c_b), .tx_u_a(tx_u_a), .tx_u_b(tx_u_b),
    .tx_block_first(tx_block_first), .cap_xfer_irq(cap_xfer_irq),
    .tx_xfer_irq(tx_xfer_irq));

  frame_partner frame_partner_inst (.ref_clk(ref_clk), .rstn(rstn),
    .run_rx(run_rx), .run_tx(run_tx), .rx_frame_stb(rx_frame_stb),
    .rx_block_start(rx_block_start), .rx_c_a(rx_c_a), .rx_c_b(rx_c_b),
    .rx_u_a(rx_u_a), .rx_u_b(rx_u_b), .tx_frame_stb(tx_frame_stb),
    .tx_c_a(tx_c_a), .tx_c_b(tx_c_b), .tx_u_a(tx_u_a), .tx_u_b(tx_u_b),
    .tx_block_first(tx_block_first), .rx_frames(rx_frames),
    .tx_frames(tx_frames), .u_seq(u_seq), .ca_seq(ca_seq),
    .cb_seq(cb_seq), .bf_seq(bf_seq), .u_any(u_any));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task tally_and_finish();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, entered and left just after a rising edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_fail++;
      $display("[ERR] %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task ptr(input int r);
    apb(OFF_PTR, 1'b1, 32'(r));
  endtask : ptr

  task put(input logic [7:0] b);
    apb(OFF_DATA, 1'b1, {24'h0, b});
  endtask : put

  task get(input logic [7:0] exp);
    apb(OFF_DATA, 1'b0, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, exp});
  endtask : get

  task frames(input int n, input logic tx);
    int lim;
    lim = 0;
    while ((tx ? tx_frames : rx_frames) < n && lim < 20000) begin
      @(posedge ref_clk);
      lim++;
    end
    if (lim >= 20000) begin
      n_fail++;
      $display("[ERR] %0t: frames stalled", $time);
    end
    run_rx <= 1'b0;
    run_tx <= 1'b0;
    repeat (80) @(posedge ref_clk);
  endtask : frames

  always @(posedge ref_clk) begin
    cycles++;
    n_cap += (cap_xfer_irq === 1'b1);
    n_tx += (tx_xfer_irq === 1'b1);
    if (cycles == 80000) begin
      n_fail++;
      $display("[ERR] %0t: timeout", $time);
      tally_and_finish();
    end
  end

  initial begin
    {rstn, psel, penable, pwrite, run_rx, run_tx} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {n_fail, comparisons, cycles, n_cap, n_tx} = '0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(OFF_CTRL, 1'b0, 32'h0);
    chk(rd, {23'h0, CTRL_RESET});
    apb(8'h40, 1'b0, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(OFF_CTRL, 1'b1, IE | TWO);
    apb(OFF_CTRL, 1'b0, 32'h0);
    chk(rd, IE | TWO);
    run_rx <= 1'b1;
    frames(192, 1'b0);
    chk(n_cap, 1);
    ptr(0);
    for (int r = 0; r < 6; r++) begin
      get(8'h40 + 8'(r));
      get(8'h90 + 8'(r));
    end
    apb(OFF_CTRL, 1'b1, IE | (32'h1 << CB_RESERVE));
    ptr(0);
    put(8'hee);
    ptr(5);
    put(8'hee);
    ptr(0);
    get(8'hee);
    apb(OFF_CTRL, 1'b1, IE | (32'h1 << CB_RESERVE) | (32'h1 << CB_SEL_B));
    ptr(0);
    get(8'hee);
    run_rx <= 1'b1;
    frames(384, 1'b0);
    chk(n_cap, 2);
    ptr(0);
    get(8'hee);
    ptr(5);
    get(8'h95);
    // capture held off while writing, as a host must for transmit data
    apb(OFF_CTRL, 1'b1, IE | (32'h1 << CB_SEL_B) | 32'h1);
    ptr(5);
    put(8'h33);
    run_rx <= 1'b1;
    frames(576, 1'b0);
    chk(n_cap, 2);
    ptr(5);
    get(8'h33);
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk(32'(rd[15:8]), 32'h2);
    apb(OFF_CTRL, 1'b1, IE | TWO | 32'h1);
    ptr(0);
    put(8'hc5);
    put(8'h0f);
    ptr(24);
    put(8'hc3);
    put(8'h5a);
    run_tx <= 1'b1;
    frames(96, 1'b1);
    chk(u_any, 1'b0);
    apb(OFF_CTRL, 1'b1, IE | TWO | 32'h1 | (32'(UMODE_BLOCK) << CB_UMODE));
    run_tx <= 1'b1;
    frames(200, 1'b1);
    chk(n_tx, 1);
    chk(u_seq, 16'hc35a);
    chk(ca_seq, 8'hc5);
    chk(cb_seq, 8'h0f);
    chk(bf_seq, 8'h80);
    tally_and_finish();
  end
endmodule : tb_status_user_buffer
